//--- shared/mmd_pkg.sv
// Constants for the memory map decoder.
package mmd_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;

  // Map boundaries.
  localparam logic [13:0] IO_LO     = 14'h0000;
  localparam logic [13:0] IO_HI     = 14'h001F;
  localparam logic [13:0] LOWWIN_LO = 14'h0020;
  localparam logic [13:0] LOWWIN_HI = 14'h004F;
  localparam logic [13:0] MRAM_LO   = 14'h0050;
  localparam logic [13:0] MRAM_HI   = 14'h00FF;
  localparam logic [13:0] HIWIN_LO  = 14'h0100;
  localparam logic [13:0] HIWIN_HI  = 14'h017F;
  localparam logic [13:0] XEP_LO    = 14'h0100;
  localparam logic [13:0] XEP_HI    = 14'h0FFF;
  localparam logic [13:0] UEP_LO    = 14'h1000;
  localparam logic [13:0] UEP_HI    = 14'h3EFF;
  localparam logic [13:0] BOOT_LO   = 14'h3F00;
  localparam logic [13:0] BOOT_HI   = 14'h3FEF;
  localparam logic [13:0] OPT_ADDR  = 14'h3FDF;
  localparam logic [13:0] NVO0_ADDR = 14'h3FF0;
  localparam logic [13:0] NVO1_ADDR = 14'h3FF1;
  localparam logic [13:0] VEC_LO    = 14'h3FF4;
  localparam logic [13:0] VEC_HI    = 14'h3FFF;
  localparam logic [13:0] DDR_BASE  = 14'h0004;
  localparam logic [13:0] STACK_TOP = 14'h00FF;
  localparam logic [13:0] STACK_BOT = 14'h00C0;

  // RAM array layout: main RAM, then low window, then high window.
  localparam int          RAM_DEPTH  = 352;
  localparam logic [8:0]  LOWWIN_IDX = 9'h0B0;
  localparam logic [8:0]  HIWIN_IDX  = 9'h0E0;

  // Option register fields.
  localparam int          OPT_LOW_BIT  = 7;
  localparam int          OPT_HIGH_BIT = 6;
  localparam logic [7:0]  OPT_RST      = 8'h00;

  // Nonvolatile configuration byte fields.
  localparam int          CFG_MODE_BIT = 0;
  localparam int          CFG_SEC_BIT  = 3;

  // Port D has no pin at bit 6.
  localparam logic [7:0]  PD_MASK  = 8'hBF;
  localparam logic [7:0]  DDR_RST  = 8'h00;
  localparam logic [7:0]  UNMAP_RD = 8'h00;

  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_RAM,
    SRC_EPROM,
    SRC_ROM,
    SRC_REG
  } mmd_src_e;
endpackage

//--- rtl/mmd_ram.sv
// Byte-wide RAM array with registered read data.
`timescale 1ns/1ps
module mmd_ram #(
  parameter int DEPTH = 352,
  parameter int AW    = 9
) (
  // Clock
  input  wire logic          clk,
  input  wire logic          ce,
  // Access
  input  wire logic          we,
  input  wire logic          re,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata_q
);
  logic [7:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("mmd_ram depth does not fit address width");
  end

  // The array holds no reset so it maps onto plain RAM cells.
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && re) begin
      rdata_q <= mem[addr];
    end
  end
endmodule

//--- rtl/mmd_map_decoder.sv
// Memory map decoder, map mode, port direction and reset pin control.
//
// Summary of operation
// - CPU clock output is the input clock divided by two.
// - Reset pin driven low for internal reset only in large-map mode.
// - All three general eight-bit ports are inputs during reset.
// - Fourth-port seven directions writable in large mode, forced input in small.
// - Each second-port pin pullup and interrupt enabled by its option bit while the pin is an input.
// - Large mode: option bits switch 48- and 128-byte windows RAM/EPROM.
// - Small mode: low window fixed EPROM, 0x0100-0x0FFF unmapped.
// - Main RAM 0x0050-0x00FF always mapped in both modes.
// - Stack addresses only span 0x00FF down to 0x00C0.
// - EPROM 0x1000-0x3EFF and vectors 0x3FF4-0x3FFF mapped in both modes.
// - Large mode also maps EPROM at 0x0100-0x0FFF.
// - Two nonvolatile option locations sit at 0x3FF0 and 0x3FF1.
// - Bootloader ROM mapped at 0x3F00-0x3FEF, except 0x3FDF, which is the option register in large mode.
// - Protection blocks external EPROM reads until erased; never for OTP.
// - Power-on reset always starts in large-map mode.
// - Window bit one selects RAM, zero EPROM; readable and writable in large mode only.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module mmd_map_decoder
  import mmd_pkg::*;
#(
  parameter int  AW  = ADDR_W,
  parameter bit  OTP = 1'b0
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  output logic               cpu_clk,
  // CPU register bus
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [7:0]    rdata,
  // Nonvolatile option values and mode control
  input  wire logic [7:0]    port_opt_bits,
  input  wire logic [7:0]    cfg_opt_bits,
  input  wire logic          cfg_load,
  input  wire logic          erase_done,
  input  wire logic          ext_access,
  output logic               small_map_mode,
  output logic               large_map_mode,
  output logic               eprom_locked,
  // EPROM and bootloader ROM arrays
  output logic               eprom_rd,
  output logic               rom_rd,
  output logic      [AW-1:0] arr_addr,
  input  wire logic [7:0]    eprom_rdata,
  input  wire logic [7:0]    rom_rdata,
  // Port direction and option controls
  output logic      [7:0]    port_a_oe,
  output logic      [7:0]    port_b_oe,
  output logic      [7:0]    port_c_oe,
  output logic      [7:0]    port_d_oe,
  output logic      [7:0]    second_port_pullup_en,
  output logic      [7:0]    second_port_irq_en,
  // Reset pin
  input  wire logic          reset_pin_n_i,
  input  wire logic          int_reset_req,
  output logic               reset_pin_n_o,
  output logic               reset_pin_n_oe,
  output logic               ext_reset_req,
  // Stack
  input  wire logic [5:0]    sp_idx,
  output logic      [AW-1:0] stack_addr
);

  if (AW != ADDR_W) begin : g_chk
    $error("mmd_map_decoder supports only a 14-bit address");
  end

  // The shared RAM array must agree with the three regions that it serves.
  localparam int MRAM_N   = int'(MRAM_HI) - int'(MRAM_LO) + 1;
  localparam int LOWWIN_N = int'(LOWWIN_HI) - int'(LOWWIN_LO) + 1;
  localparam int HIWIN_N  = int'(HIWIN_HI) - int'(HIWIN_LO) + 1;

  if (RAM_DEPTH != MRAM_N + LOWWIN_N + HIWIN_N) begin : g_chk_depth
    $error("mmd_map_decoder RAM depth does not match the mapped regions");
  end
  if (int'(LOWWIN_IDX) != MRAM_N || int'(HIWIN_IDX) != MRAM_N + LOWWIN_N) begin : g_chk_idx
    $error("mmd_map_decoder RAM window offsets overlap");
  end
  // The high window decode is nested inside the extra EPROM range.
  if (HIWIN_LO < XEP_LO || HIWIN_HI > XEP_HI) begin : g_chk_hiwin
    $error("mmd_map_decoder high window lies outside the extra EPROM range");
  end
  // A six-bit stack index can only reach an aligned top block of 64 bytes.
  if (STACK_BOT[5:0] != 6'h00 || (STACK_BOT | 14'h003F) != STACK_TOP) begin : g_chk_stack
    $error("mmd_map_decoder stack window does not fit the stack index");
  end
  // Direction registers are picked by the low two address bits.
  if (DDR_BASE[1:0] != 2'h0) begin : g_chk_ddr
    $error("mmd_map_decoder direction registers must be aligned");
  end

  function automatic logic in_rng(input logic [13:0] a,
                                  input logic [13:0] lo,
                                  input logic [13:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  logic       cpu_clk_q;
  logic       small_q;
  logic       lock_q;
  logic [7:0] opt_q;
  logic [7:0] ddr_q [4];
  logic [7:0] reg_q;
  mmd_src_e   src_d;
  mmd_src_e   src_q;
  logic [8:0] ram_idx;
  logic [7:0] ram_rdata;
  logic       low_ram;
  logic       high_ram;

  // Clock divider.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_clk_q <= 1'b0;
    end else if (ce) begin
      cpu_clk_q <= ~cpu_clk_q;
    end
  end
  assign cpu_clk = cpu_clk_q;

  // Map mode. A later configuration load may leave large mode, but
  // power-on reset never honours the programmed mode bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      small_q <= 1'b0;
    end else if (ce && cfg_load) begin
      small_q <= cfg_opt_bits[CFG_MODE_BIT];
    end
  end
  assign small_map_mode = small_q;
  assign large_map_mode = ~small_q;

  // Protection latch. The set term wins over an erase in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (ce) begin
      if (cfg_opt_bits[CFG_SEC_BIT]) begin
        lock_q <= 1'b1;
      end else if (erase_done && !OTP) begin
        lock_q <= 1'b0;
      end
    end
  end
  assign eprom_locked = lock_q;

  // Option register window bits.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opt_q <= OPT_RST;
    end else if (ce && wr && !small_q && addr == OPT_ADDR) begin
      opt_q <= wdata;
    end
  end
  assign low_ram  = opt_q[OPT_LOW_BIT];
  assign high_ram = opt_q[OPT_HIGH_BIT];

  // Direction registers for the four ports.
  for (genvar p = 0; p < 4; p++) begin : g_ddr
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ddr_q[p] <= DDR_RST;
      end else if (ce && wr && addr == DDR_BASE + 14'(p)) begin
        if (p != 3) begin
          ddr_q[p] <= wdata;
        end else if (!small_q) begin
          ddr_q[p] <= wdata & PD_MASK;
        end
      end
    end
  end

  assign port_a_oe = ddr_q[0];
  assign port_b_oe = ddr_q[1];
  assign port_c_oe = ddr_q[2];
  assign port_d_oe = small_q ? 8'h00 : ddr_q[3];

  // Option bits apply while the pin is an input.
  for (genvar b = 0; b < 8; b++) begin : g_pb
    assign second_port_pullup_en[b] = port_opt_bits[b] & ~ddr_q[1][b];
    assign second_port_irq_en[b]    = port_opt_bits[b] & ~ddr_q[1][b];
  end

  // Reset pin: open drain, pulled low only in large mode.
  assign reset_pin_n_o  = 1'b0;
  assign reset_pin_n_oe = ~small_q & (rst | int_reset_req);
  assign ext_reset_req  = ~reset_pin_n_i;

  // Stack window.
  assign stack_addr = STACK_BOT | {8'h00, sp_idx};

  // Address decode.
  always_comb begin
    src_d = SRC_NONE;
    if (in_rng(addr, IO_LO, IO_HI)) begin
      if (in_rng(addr, DDR_BASE, DDR_BASE + 14'h0002)) begin
        src_d = SRC_REG;
      end else if (addr == DDR_BASE + 14'h0003 && !small_q) begin
        src_d = SRC_REG;
      end
    end else if (in_rng(addr, LOWWIN_LO, LOWWIN_HI)) begin
      src_d = (!small_q && low_ram) ? SRC_RAM : SRC_EPROM;
    end else if (in_rng(addr, MRAM_LO, MRAM_HI)) begin
      src_d = SRC_RAM;
    end else if (in_rng(addr, XEP_LO, XEP_HI)) begin
      if (small_q) begin
        src_d = SRC_NONE;
      end else if (in_rng(addr, HIWIN_LO, HIWIN_HI) && high_ram) begin
        src_d = SRC_RAM;
      end else begin
        src_d = SRC_EPROM;
      end
    end else if (in_rng(addr, UEP_LO, UEP_HI)) begin
      src_d = SRC_EPROM;
    end else if (addr == OPT_ADDR && !small_q) begin
      src_d = SRC_REG;
    end else if (in_rng(addr, BOOT_LO, BOOT_HI)) begin
      src_d = SRC_ROM;
    end else if (addr == NVO0_ADDR || addr == NVO1_ADDR) begin
      src_d = SRC_REG;
    end else if (in_rng(addr, VEC_LO, VEC_HI)) begin
      src_d = SRC_EPROM;
    end
    // External reads of a protected array see only the constant.
    if (src_d == SRC_EPROM && lock_q && ext_access) begin
      src_d = SRC_NONE;
    end
  end

  // RAM index: main RAM first, then the two windows.
  always_comb begin
    ram_idx = 9'(addr - MRAM_LO);
    if (in_rng(addr, LOWWIN_LO, LOWWIN_HI)) begin
      ram_idx = LOWWIN_IDX + 9'(addr - LOWWIN_LO);
    end else if (in_rng(addr, HIWIN_LO, HIWIN_HI)) begin
      ram_idx = HIWIN_IDX + 9'(addr - HIWIN_LO);
    end
  end

  mmd_ram #(
    .DEPTH (RAM_DEPTH),
    .AW    (9)
  ) u_ram (
    .clk     (clk),
    .ce      (ce),
    .we      (wr && src_d == SRC_RAM),
    .re      (rd && src_d == SRC_RAM),
    .addr    (ram_idx),
    .wdata   (wdata),
    .rdata_q (ram_rdata)
  );

  // Array strobes; writes to EPROM and ROM are ignored here.
  assign eprom_rd = ce & rd & (src_d == SRC_EPROM);
  assign rom_rd   = ce & rd & (src_d == SRC_ROM);
  assign arr_addr = addr;

  // Local register read capture.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_q <= UNMAP_RD;
    end else if (ce && rd) begin
      if (addr == OPT_ADDR) begin
        reg_q <= opt_q;
      end else if (addr == NVO0_ADDR) begin
        reg_q <= port_opt_bits;
      end else if (addr == NVO1_ADDR) begin
        reg_q <= cfg_opt_bits;
      end else begin
        reg_q <= ddr_q[addr[1:0]];
      end
    end
  end

  // Source of the answer in the cycle after a read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_q <= SRC_NONE;
    end else if (ce) begin
      src_q <= rd ? src_d : SRC_NONE;
    end
  end

  // Arrays answer one cycle after their strobe, so data meets src_q.
  always_comb begin
    case (src_q)
      SRC_RAM:   rdata = ram_rdata;
      SRC_EPROM: rdata = eprom_rdata;
      SRC_ROM:   rdata = rom_rdata;
      SRC_REG:   rdata = reg_q;
      default:   rdata = UNMAP_RD;
    endcase
  end
endmodule

//--- test/mmd_array_model.sv
// EPROM and bootloader ROM array model for the memory map decoder.
`timescale 1ns/1ps
module mmd_array_model (
  // Clock
  input  wire logic        clk,
  // Array reads
  input  wire logic        eprom_rd,
  input  wire logic        rom_rd,
  input  wire logic [13:0] arr_addr,
  output logic      [7:0]  eprom_rdata,
  output logic      [7:0]  rom_rdata
);
  // Idle cycles flip the byte, so a read taken a cycle late never matches.
  always @(posedge clk) begin
    eprom_rdata <= eprom_rd ? (arr_addr[7:0] ^ 8'hA5) : ~eprom_rdata;
    rom_rdata   <= rom_rd ? (arr_addr[7:0] ^ 8'h3C) : ~rom_rdata;
  end
endmodule

//--- test/mmd_map_decoder_asserts.sv
// Port assertions for the memory map decoder.
`timescale 1ns/1ps
module mmd_map_decoder_asserts
  import mmd_pkg::*;
#(parameter int AW = ADDR_W) (
  // Clock and bus
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          ce,
  input wire logic          cpu_clk,
  input wire logic [AW-1:0] addr,
  input wire logic          rd,
  input wire logic [7:0]    rdata,
  input wire logic          ext_access,
  input wire logic          eprom_rd,
  input wire logic          rom_rd,
  // Mode, ports and reset pin
  input wire logic          small_map_mode,
  input wire logic          large_map_mode,
  input wire logic [7:0]    port_b_oe,
  input wire logic [7:0]    port_d_oe,
  input wire logic [7:0]    port_opt_bits,
  input wire logic [7:0]    second_port_pullup_en,
  input wire logic          int_reset_req,
  input wire logic          reset_pin_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic go;
  assign go = rd && ce;
  // The first edge after release still sees reset values, so it is skipped.
  a_half_clock: assert property (!$past(rst) && ce |=> cpu_clk != $past(cpu_clk))
    else $error("cpu clock not halved");
  a_pin_drive: assert property (int_reset_req |-> reset_pin_n_oe == large_map_mode)
    else $error("reset pin drive wrong");
  a_reset_state: assert property ($fell(rst) |-> large_map_mode && !port_b_oe)
    else $error("reset state wrong");
  a_portd_small: assert property (small_map_mode |-> port_d_oe == 8'h00)
    else $error("port d driven in small map");
  a_pullup_opt: assert property (second_port_pullup_en == (port_opt_bits & ~port_b_oe))
    else $error("pullup enable wrong");
  a_small_gap: assert property (go && small_map_mode && addr inside {[XEP_LO:XEP_HI]}
    |-> !eprom_rd ##1 rdata == UNMAP_RD) else $error("small map gap mapped");
  a_eprom_strobe: assert property (go && !ext_access
    && addr inside {[UEP_LO:UEP_HI], [VEC_LO:VEC_HI]} |-> eprom_rd && !rom_rd)
    else $error("eprom strobe missing");
  a_boot_strobe: assert property (go && addr inside {[BOOT_LO:BOOT_HI]}
    && !(large_map_mode && addr == OPT_ADDR) |-> rom_rd && !eprom_rd)
    else $error("rom strobe missing");
  c_small_read: cover property (go && small_map_mode);
  c_boot_read: cover property (rom_rd);
  c_pin_drive: cover property (reset_pin_n_oe && int_reset_req);
endmodule

//--- test/mmd_map_decoder_tb.sv
// Self-checking testbench for the memory map decoder.
`timescale 1ns/1ps
module mmd_map_decoder_tb;
  import mmd_pkg::*;
  logic        clk, rst, ce, cpu_clk, wr, rd, cfg_load, erase_done, ext_access;
  logic        small_map_mode, large_map_mode, eprom_locked, eprom_rd, rom_rd;
  logic        reset_pin_n_i, int_reset_req, reset_pin_n_o, reset_pin_n_oe, ext_reset_req;
  logic [13:0] addr, arr_addr, stack_addr;
  logic [7:0]  wdata, rdata, port_opt_bits, cfg_opt_bits, eprom_rdata, rom_rdata;
  logic [7:0]  port_a_oe, port_b_oe, port_c_oe, port_d_oe;
  logic [7:0]  second_port_pullup_en, second_port_irq_en;
  logic [5:0]  sp_idx;
  int          mismatches, tests_run;
  localparam logic [13:0] EA [6] = '{14'h1000, 14'h3EFF, 14'h3FF4, 14'h3FFF, 14'h0100, 14'h0FFF};

  mmd_map_decoder dut_u (
    .clk                   (clk),
    .rst                   (rst),
    .ce                    (ce),
    .cpu_clk               (cpu_clk),
    .addr                  (addr),
    .wdata                 (wdata),
    .wr                    (wr),
    .rd                    (rd),
    .rdata                 (rdata),
    .port_opt_bits         (port_opt_bits),
    .cfg_opt_bits          (cfg_opt_bits),
    .cfg_load              (cfg_load),
    .erase_done            (erase_done),
    .ext_access            (ext_access),
    .small_map_mode        (small_map_mode),
    .large_map_mode        (large_map_mode),
    .eprom_locked          (eprom_locked),
    .eprom_rd              (eprom_rd),
    .rom_rd                (rom_rd),
    .arr_addr              (arr_addr),
    .eprom_rdata           (eprom_rdata),
    .rom_rdata             (rom_rdata),
    .port_a_oe             (port_a_oe),
    .port_b_oe             (port_b_oe),
    .port_c_oe             (port_c_oe),
    .port_d_oe             (port_d_oe),
    .second_port_pullup_en (second_port_pullup_en),
    .second_port_irq_en    (second_port_irq_en),
    .reset_pin_n_i         (reset_pin_n_i),
    .int_reset_req         (int_reset_req),
    .reset_pin_n_o         (reset_pin_n_o),
    .reset_pin_n_oe        (reset_pin_n_oe),
    .ext_reset_req         (ext_reset_req),
    .sp_idx                (sp_idx),
    .stack_addr            (stack_addr)
  );
  mmd_array_model arr_u (
    .clk         (clk),
    .eprom_rd    (eprom_rd),
    .rom_rd      (rom_rd),
    .arr_addr    (arr_addr),
    .eprom_rdata (eprom_rdata),
    .rom_rdata   (rom_rdata)
  );
  // The reset pin has a pull-up, so it reads high whenever nobody drives it.
  assign reset_pin_n_i = reset_pin_n_oe ? reset_pin_n_o : 1'b1;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_b(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_b(input logic [13:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic cfg(input logic [7:0] v);
    @(posedge clk);
    cfg_opt_bits <= v;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
  endtask

  task automatic t_ram();
    wr_b(MRAM_LO, 8'h11);
    wr_b(MRAM_HI, 8'hEE);
    rd_b(MRAM_LO, 8'h11);
    rd_b(MRAM_HI, 8'hEE);
    @(posedge clk);
    sp_idx <= 6'h3F;
    #1 chk(stack_addr, STACK_TOP);
    @(posedge clk);
    sp_idx <= 6'h00;
    #1 chk(stack_addr, STACK_BOT);
    chk({port_a_oe, port_c_oe}, 16'h0000);
    $display("test ram done");
  endtask

  task automatic t_window();
    wr_b(OPT_ADDR, 8'hC0);
    rd_b(OPT_ADDR, 8'hC0);
    wr_b(LOWWIN_LO, 8'h5A);
    wr_b(HIWIN_HI, 8'hC3);
    rd_b(LOWWIN_LO, 8'h5A);
    rd_b(HIWIN_HI, 8'hC3);
    wr_b(OPT_ADDR, 8'h00);
    rd_b(LOWWIN_LO, 8'h85);
    rd_b(HIWIN_HI, 8'hDA);
    $display("test window done");
  endtask

  task automatic t_map();
    for (int i = 0; i < 6; i++) begin
      rd_b(EA[i], EA[i][7:0] ^ 8'hA5);
    end
    rd_b(BOOT_LO, 8'h3C);
    rd_b(BOOT_HI, 8'hD3);
    chk(arr_addr, BOOT_HI);
    rd_b(NVO0_ADDR, 8'hFF);
    @(posedge clk);
    cfg_opt_bits <= 8'h62;
    rd_b(NVO1_ADDR, 8'h62);
    wr_b(14'h3FF2, 8'h77);
    rd_b(14'h3FF2, UNMAP_RD);
    $display("test map done");
  endtask

  task automatic t_ports();
    wr_b(14'h0007, 8'hFF);
    #1 chk(port_d_oe, PD_MASK);
    rd_b(14'h0007, PD_MASK);
    wr_b(14'h0005, 8'h0F);
    #1 chk({second_port_pullup_en, second_port_irq_en}, 16'hF0F0);
    @(posedge clk);
    int_reset_req <= 1'b1;
    #1 chk({reset_pin_n_oe, ext_reset_req}, 16'h0003);
    $display("test ports done");
  endtask

  task automatic t_small();
    cfg(8'h01);
    #1 chk({small_map_mode, port_d_oe, reset_pin_n_oe}, 16'h0200);
    wr_b(14'h0007, 8'h00);
    rd_b(14'h0007, UNMAP_RD);
    @(posedge clk);
    int_reset_req <= 1'b0;
    rd_b(XEP_LO, UNMAP_RD);
    wr_b(OPT_ADDR, 8'h80);
    rd_b(LOWWIN_LO, 8'h85);
    rd_b(MRAM_HI, 8'hEE);
    cfg(8'h00);
    #1 chk(port_d_oe, PD_MASK);
    rd_b(OPT_ADDR, 8'h00);
    $display("test small done");
  endtask

  task automatic t_protect();
    @(posedge clk);
    ext_access <= 1'b1;
    erase_done <= 1'b1;
    cfg(8'h08);
    erase_done <= 1'b0;
    #1 chk(eprom_locked, 1'b1);
    rd_b(UEP_LO, UNMAP_RD);
    @(posedge clk);
    cfg_opt_bits <= 8'h00;
    erase_done <= 1'b1;
    @(posedge clk);
    erase_done <= 1'b0;
    #1 chk(eprom_locked, 1'b0);
    rd_b(UEP_LO, 8'hA5);
    $display("test protect done");
  endtask

  task automatic t_freeze();
    logic c;
    @(posedge clk);
    ce <= 1'b0;
    #1 c = cpu_clk;
    @(posedge clk);
    ce <= 1'b1;
    #1 chk(cpu_clk, c);
    @(posedge clk);
    #1 chk(cpu_clk, !c);
    $display("test freeze done");
  endtask

  task automatic t_reset();
    cfg(8'h01);
    wr_b(14'h0004, 8'hFF);
    @(posedge clk);
    rst <= 1'b1;
    #1 chk({large_map_mode, reset_pin_n_oe, port_a_oe}, 16'h0300);
    chk({port_b_oe, port_d_oe}, 16'h0000);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_b(XEP_LO, 8'hA5);
    $display("test reset done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    {rst, ce, wr, rd, cfg_load, erase_done, ext_access, int_reset_req} = 8'h C0;
    {addr, wdata, cfg_opt_bits, sp_idx} = '0;
    port_opt_bits = 8'hFF;
    mismatches = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    chk({reset_pin_n_oe, ext_reset_req, large_map_mode}, 16'h0007);
    rst <= 1'b0;
    t_ram();
    t_freeze();
    t_window();
    t_map();
    t_ports();
    t_small();
    t_protect();
    t_reset();
    final_report();
  end

  // The tests take well under a thousand cycles; this cuts a hang short.
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule

bind mmd_map_decoder mmd_map_decoder_asserts #(.AW(AW)) chk_u (
  .clk                   (clk),
  .rst                   (rst),
  .ce                    (ce),
  .cpu_clk               (cpu_clk),
  .addr                  (addr),
  .rd                    (rd),
  .rdata                 (rdata),
  .ext_access            (ext_access),
  .eprom_rd              (eprom_rd),
  .rom_rd                (rom_rd),
  .small_map_mode        (small_map_mode),
  .large_map_mode        (large_map_mode),
  .port_b_oe             (port_b_oe),
  .port_d_oe             (port_d_oe),
  .port_opt_bits         (port_opt_bits),
  .second_port_pullup_en (second_port_pullup_en),
  .int_reset_req         (int_reset_req),
  .reset_pin_n_oe        (reset_pin_n_oe)
);
